// [core/fsk_tx_pkg.sv]
// shared constants and types for the fsk transmit modulator
package fsk_tx_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL0_OFF = 12'h000;
  localparam logic [11:0] CTRL1_OFF = 12'h004;
  localparam logic [11:0] CTRL2_OFF = 12'h008;
  localparam logic [11:0] CTRL3_OFF = 12'h00c;
  localparam logic [11:0] STATUS_OFF = 12'h010;
  // field positions
  localparam int RX_SELECT_BIT = 27;
  localparam int HALVING_BIT = 18;
  localparam int KEY_LSB = 4;
  localparam int AMP_ON_BIT = 7;
  localparam int RAMP_LSB = 8;
  localparam int BIAS_LSB = 11;
  localparam int LEVEL_LSB = 13;
  localparam int DEV_LSB = 19;
  localparam int CLKINV_LSB = 28;
  localparam int DEMOD_LSB = 6;
  localparam int RECOV_LSB = 10;
  // reset values: receive selected, middle bias, deviation 1, dividers 1
  localparam logic [31:0] CTRL0_RST = 32'h0800_0000;
  localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL2_RST = 32'h0008_0800;
  localparam logic [31:0] CTRL3_RST = 32'h0000_0440;
  // keying select codes
  localparam logic [2:0] KEY_OVERSAMPLE = 3'h4;
  localparam logic [1:0] KEY_LOW_3FSK = 2'h2;
  localparam logic [1:0] KEY_LOW_4FSK = 2'h3;
  // bit clock phase: 32 oversample ticks per bit
  localparam logic [4:0] PHASE_RISE = 5'h0f;
  localparam logic [4:0] PHASE_FALL = 5'h1f;
  // level codes advanced per bit period for each ramp setting
  localparam logic [6:0] RAMP_STEP [8] = '{7'h01, 7'h02, 7'h03, 7'h04,
                                          7'h08, 7'h10, 7'h20, 7'h40};
  typedef enum logic [1:0] {amp_off, amp_up, amp_on, amp_down} amp_state_t;
  typedef enum logic [1:0] {key_2fsk, key_os, key_3fsk, key_4fsk} key_t;
endpackage

// [core/fsk_tx_mod.sv]
// fsk transmit modulator: bit clock, symbol mapping, amplifier ramp, apb registers
`timescale 1ns/10ps
`default_nettype none
module fsk_tx_mod
  import fsk_tx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_bit_input,
  output logic transceive_clock_pin,
  output logic amp_output_on,
  output logic [5:0] amp_level,
  output logic [1:0] amp_bias_select,
  output logic signed [2:0] symbol,
  output logic signed [12:0] freq_offset
);
  logic [31:0] ctrl0_reg, ctrl0_next, ctrl1_reg, ctrl1_next;
  logic [31:0] ctrl2_reg, ctrl2_next, ctrl3_reg, ctrl3_next;
  logic clk_started_reg, clk_started_next;
  logic [11:0] div_cnt_reg, div_cnt_next;
  logic [4:0] phase_reg, phase_next;
  logic p1_reg, p1_next, p2_reg, p2_next;
  logic half_reg, half_next, msb_reg, msb_next;
  logic signed [2:0] sym_reg, sym_next;
  logic signed [12:0] offset_reg, offset_next;
  amp_state_t amp_state_reg, amp_state_next;
  logic [5:0] amp_level_reg, amp_level_next;
  logic access, hit, wr;
  logic [11:0] div_base;
  logic os_tick, rise_tick, fall_tick, sample_ev, bit_tick;
  logic clk_inv, rx_sel, tx_active, amp_en;
  logic [2:0] key_code;
  key_t key;
  logic [8:0] dev_word;
  logic [9:0] dev_eff;
  logic [5:0] target;
  logic [6:0] step;
  logic [7:0] lvl_sum;
  logic signed [13:0] prod;

  // apb decode; the slave never waits, so pready is constant high
  assign access = psel && penable;
  assign hit = (paddr == CTRL0_OFF) || (paddr == CTRL1_OFF) || (paddr == CTRL2_OFF)
    || (paddr == CTRL3_OFF) || (paddr == STATUS_OFF);
  assign wr = access && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  // read mux; unmapped reads return zero
  always_comb begin
    case (paddr)
      CTRL0_OFF: prdata = ctrl0_reg;
      CTRL1_OFF: prdata = ctrl1_reg;
      CTRL2_OFF: prdata = ctrl2_reg;
      CTRL3_OFF: prdata = ctrl3_reg;
      STATUS_OFF: prdata = {18'h0, clk_started_reg, half_reg, amp_state_reg,
                            amp_level_reg, 1'b0, sym_reg};
      default: prdata = 32'h0;
    endcase
  end

  // register writes; a word 3 write arms the bit clock for good
  always_comb begin
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    ctrl3_next = ctrl3_reg;
    clk_started_next = clk_started_reg;
    if (wr) begin
      case (paddr)
        CTRL0_OFF: ctrl0_next = pwdata;
        CTRL1_OFF: ctrl1_next = pwdata;
        CTRL2_OFF: ctrl2_next = pwdata;
        CTRL3_OFF: begin
          ctrl3_next = pwdata;
          clk_started_next = 1'b1;
        end
        default: ctrl0_next = ctrl0_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= CTRL0_RST;
      ctrl1_reg <= CTRL1_RST;
      ctrl2_reg <= CTRL2_RST;
      ctrl3_reg <= CTRL3_RST;
      clk_started_reg <= 1'b0;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      ctrl3_reg <= ctrl3_next;
      clk_started_reg <= clk_started_next;
    end
  end

  // field views of the control words
  assign rx_sel = ctrl0_reg[RX_SELECT_BIT];
  assign key_code = ctrl2_reg[KEY_LSB +: 3];
  assign amp_en = ctrl2_reg[AMP_ON_BIT];
  assign step = RAMP_STEP[ctrl2_reg[RAMP_LSB +: 3]];
  assign amp_bias_select = ctrl2_reg[BIAS_LSB +: 2];
  assign target = ctrl2_reg[LEVEL_LSB +: 6];
  assign dev_word = ctrl2_reg[DEV_LSB +: 9];
  assign clk_inv = |ctrl2_reg[CLKINV_LSB +: 2];
  assign tx_active = clk_started_reg && !rx_sel;

  // filtered variants share the unfiltered symbol path
  always_comb begin
    if (key_code == KEY_OVERSAMPLE) key = key_os;
    else if (key_code[1:0] == KEY_LOW_3FSK) key = key_3fsk;
    else if (key_code[1:0] == KEY_LOW_4FSK) key = key_4fsk;
    else key = key_2fsk;
  end

  // oversample tick every demod x recovery cycles; a zero product (either divider zero) acts as one
  always_comb begin
    div_base = 12'(ctrl3_reg[DEMOD_LSB +: 4]) * 12'(ctrl3_reg[RECOV_LSB +: 8]);
    if (div_base == 12'h000) div_base = 12'h001;
  end
  assign os_tick = clk_started_reg && (div_cnt_reg == div_base - 12'h001);
  assign rise_tick = os_tick && (phase_reg == PHASE_RISE);
  assign fall_tick = os_tick && (phase_reg == PHASE_FALL);
  assign bit_tick = fall_tick;

  // divider chain: 32 phases per bit give the bit clock
  always_comb begin
    div_cnt_next = div_cnt_reg;
    phase_next = phase_reg;
    if (clk_started_reg) begin
      div_cnt_next = os_tick ? 12'h000 : div_cnt_reg + 12'h001;
      if (os_tick) phase_next = phase_reg + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 12'h000;
      phase_reg <= 5'h00;
    end else begin
      div_cnt_reg <= div_cnt_next;
      phase_reg <= phase_next;
    end
  end

  // pin high for phases 16..31 (0..15 when inverted); quiet until armed and in oversampled mode
  assign transceive_clock_pin = clk_started_reg && (key != key_os)
    && (phase_reg[4] ^ clk_inv);
  // sample on the pin's rising edge; oversampled takes every tick
  assign sample_ev = (key == key_os) ? os_tick
    : (clk_inv ? fall_tick : rise_tick);

  // deviation scale: units of pfd / 2^17, halving drops one bit
  assign dev_eff = ctrl1_reg[HALVING_BIT] ? {1'b0, dev_word} : {dev_word, 1'b0};
  assign prod = sym_next * $signed({1'b0, dev_eff});

  // symbol mapper; precoder state clears whenever transmit stops
  always_comb begin
    p1_next = p1_reg;
    p2_next = p2_reg;
    half_next = half_reg;
    msb_next = msb_reg;
    sym_next = sym_reg;
    if (!tx_active) begin
      p1_next = 1'b0;
      p2_next = 1'b0;
      half_next = 1'b0;
      sym_next = 3'sd0;
    end else if (sample_ev) begin
      case (key)
        key_2fsk, key_os: sym_next = transmit_bit_input ? 3'sd1 : -3'sd1;
        key_3fsk: begin
          p1_next = transmit_bit_input ^ p2_reg;
          p2_next = p1_reg;
          sym_next = $signed({2'b00, p1_next}) - $signed({2'b00, p2_reg});
        end
        key_4fsk: begin
          half_next = !half_reg;
          if (!half_reg) begin
            msb_next = transmit_bit_input;
          end else begin
            case ({msb_reg, transmit_bit_input})
              2'b00: sym_next = -3'sd3;
              2'b01: sym_next = -3'sd1;
              2'b11: sym_next = 3'sd1;
              default: sym_next = 3'sd3;
            endcase
          end
        end
        default: sym_next = 3'sd0;
      endcase
    end
    offset_next = prod[12:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_reg <= 1'b0;
      p2_reg <= 1'b0;
      half_reg <= 1'b0;
      msb_reg <= 1'b0;
      sym_reg <= 3'sd0;
      offset_reg <= 13'sd0;
    end else begin
      p1_reg <= p1_next;
      p2_reg <= p2_next;
      half_reg <= half_next;
      msb_reg <= msb_next;
      sym_reg <= sym_next;
      offset_reg <= offset_next;
    end
  end

  assign symbol = sym_reg;
  assign freq_offset = offset_reg;

  // amplifier ramp; steps only once per bit period to limit splatter
  always_comb begin
    amp_state_next = amp_state_reg;
    amp_level_next = amp_level_reg;
    lvl_sum = 8'(amp_level_reg) + 8'(step);
    case (amp_state_reg)
      amp_off: begin
        amp_level_next = 6'h00;
        if (amp_en && tx_active) amp_state_next = amp_up;
      end
      amp_up: begin
        if (!amp_en) begin
          amp_state_next = amp_down;
        end else if (amp_level_reg >= target) begin
          amp_state_next = amp_on;
        end else if (bit_tick) begin
          amp_level_next = (lvl_sum >= 8'(target)) ? target : lvl_sum[5:0];
        end
      end
      amp_on: begin
        amp_level_next = target;
        if (!amp_en) amp_state_next = amp_down;
      end
      amp_down: begin
        if (amp_level_reg == 6'h00) begin
          amp_state_next = amp_off;
        end else if (bit_tick) begin
          amp_level_next = (7'(amp_level_reg) > step) ? amp_level_reg - step[5:0]
            : 6'h00;
        end
      end
      default: amp_state_next = amp_off;
    endcase
    // leaving transmit cuts the amplifier at once, no ramp down
    if (rx_sel) begin
      amp_state_next = amp_off;
      amp_level_next = 6'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_state_reg <= amp_off;
      amp_level_reg <= 6'h00;
    end else begin
      amp_state_reg <= amp_state_next;
      amp_level_reg <= amp_level_next;
    end
  end

  assign amp_output_on = (amp_state_reg != amp_off);
  assign amp_level = amp_level_reg;

  // checks on the block's own behaviour
  a_hard_cut: assert property (@(posedge pclk) disable iff (!presetn)
    rx_sel |=> amp_level_reg == 6'h00 && !amp_output_on)
    else $error("amplifier not cut in receive");
  a_off_state: assert property (@(posedge pclk) disable iff (!presetn)
    amp_state_reg == amp_off |-> !amp_output_on && amp_level_reg == 6'h00)
    else $error("amplifier active while off");
  a_ramp_paced: assert property (@(posedge pclk) disable iff (!presetn)
    amp_state_reg == amp_up && amp_en && !rx_sel && !bit_tick
    |=> $stable(amp_level_reg))
    else $error("ramp moved between bit periods");
  a_clock_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_started_reg || key == key_os) |-> !transceive_clock_pin)
    else $error("bit clock driven when it must stay quiet");
  a_clock_arm: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == CTRL3_OFF |=> clk_started_reg)
    else $error("word 3 write did not arm the clock");
  a_2fsk_map: assert property (@(posedge pclk) disable iff (!presetn)
    sample_ev && tx_active && key == key_2fsk
    |=> sym_reg == ($past(transmit_bit_input) ? 3'sd1 : -3'sd1))
    else $error("2fsk symbol wrong");
  a_3fsk_code: assert property (@(posedge pclk) disable iff (!presetn)
    sample_ev && tx_active && key == key_3fsk
    |=> p1_reg == ($past(transmit_bit_input) ^ $past(p2_reg))
    && sym_reg == $signed({2'b00, p1_reg}) - $signed({2'b00, $past(p2_reg)}))
    else $error("3fsk precoder or encoder wrong");
  a_4fsk_half: assert property (@(posedge pclk) disable iff (!presetn)
    sample_ev && tx_active && key == key_4fsk && !half_reg |=> $stable(sym_reg))
    else $error("4fsk symbol changed on first bit");
  a_4fsk_outer: assert property (@(posedge pclk) disable iff (!presetn)
    sample_ev && tx_active && key == key_4fsk && half_reg && msb_reg
    && !transmit_bit_input
    |=> sym_reg == 3'sd3 && freq_offset == 13'(3 * $past(dev_eff)))
    else $error("4fsk outer deviation wrong");
endmodule
`default_nettype wire

// [dv/host_bit_source.sv]
// host model: serial bit source paced by the device bit clock
`timescale 1ns/10ps
`default_nettype none
module host_bit_source (
  input wire logic pclk,
  input wire logic transceive_clock_pin,
  output logic transmit_bit_input
);
  logic q[$];
  logic pin_seen;
  initial begin
    transmit_bit_input = 1'b0;
    pin_seen = 1'b0;
  end
  // next bit just after each clock rise, so it is steady around both sampling edges
  always @(posedge pclk) begin
    if (transceive_clock_pin && !pin_seen && q.size() > 0) begin
      void'(q.pop_front());
    end
    pin_seen <= transceive_clock_pin;
    // idle line toggles so a stale bit never passes for data
    transmit_bit_input <= (q.size() > 0) ? q[0] : ~transmit_bit_input;
  end
endmodule
`default_nettype wire

// [dv/fsk_transmit_modulator_tb.sv]
// testbench for the fsk transmit modulator
`timescale 1ns/10ps
`default_nettype none
module fsk_transmit_modulator_tb;
  import fsk_tx_pkg::*;
  localparam int DEV = 5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_bit, pin, amp_on, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] amp_level;
  logic [1:0] bias;
  logic signed [2:0] symbol;
  logic signed [12:0] freq_offset;
  int n_errors = 0;
  int num_checks = 0;
  fsk_tx_mod DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmit_bit_input(tx_bit), .transceive_clock_pin(pin),
    .amp_output_on(amp_on), .amp_level(amp_level), .amp_bias_select(bias),
    .symbol(symbol), .freq_offset(freq_offset));
  host_bit_source host (.pclk(pclk), .transceive_clock_pin(pin), .transmit_bit_input(tx_bit));
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; bounded wait on pready, data taken at the same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_pin(input logic v);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge pclk);
      #1;
      if (pin === v) break;
    end
    if (i == 200) begin
      n_errors++;
      finish_test();
    end
  endtask
  function automatic logic [31:0] ctrl2(logic [2:0] key, logic on, logic [2:0] ramp,
                                        logic [1:0] bs, logic [5:0] lvl);
    ctrl2 = (32'(key) << KEY_LSB) | (32'(on) << AMP_ON_BIT) | (32'(ramp) << RAMP_LSB);
    ctrl2 = ctrl2 | (32'(bs) << BIAS_LSB) | (32'(lvl) << LEVEL_LSB) | (32'(DEV) << DEV_LSB);
  endfunction
  task automatic test_regs();
    apb(1'b0, CTRL0_OFF, 32'h0);
    check(rd, CTRL0_RST);
    apb(1'b0, CTRL2_OFF, 32'h0);
    check(rd, CTRL2_RST);
    check({30'h0, bias}, 32'h1);
    apb(1'b0, CTRL3_OFF, 32'h0);
    check(rd, CTRL3_RST);
    apb(1'b0, 12'h014, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    cyc(80);
    check({31'h0, pin}, 32'h0);
    $display("test regs done");
  endtask
  // recovery divider 2 gives 64 cycles a bit
  task automatic test_clock();
    time t;
    apb(1'b1, CTRL3_OFF, 32'h0000_0840);
    wait_pin(1'b1);
    t = $time;
    wait_pin(1'b0);
    wait_pin(1'b1);
    check(32'(($time - t) / 25), 32'h40);
    $display("test clock done");
  endtask
  // state cleared in receive, bits queued, then transmit starts just after a clock fall
  task automatic run_mode(input logic [2:0] key, input logic half, input logic [9:0] bits,
                          input int n, input logic [29:0] exp, input int step);
    int i;
    int k;
    logic [2:0] s;
    logic signed [12:0] eo;
    apb(1'b1, CTRL0_OFF, 32'h0800_0000);
    apb(1'b1, CTRL1_OFF, 32'(half) << HALVING_BIT);
    apb(1'b1, CTRL2_OFF, ctrl2(key, 1'b0, 3'h0, 2'h1, 6'h0));
    wait_pin(1'b0);
    for (i = 0; i < n; i++) host.q.push_back(bits[n-1-i]);
    apb(1'b1, CTRL0_OFF, 32'h0);
    k = 0;
    for (i = 0; i < n; i++) begin
      wait_pin(1'b1);
      cyc(1);
      #1;
      if ((i + 1) % step == 0) begin
        s = exp[3*(n/step-1-k) +: 3];
        eo = 13'($signed(s) * (half ? DEV : 2 * DEV));
        check({29'h0, symbol}, {29'h0, s});
        check({19'h0, freq_offset}, {19'h0, eo});
        k++;
      end
      wait_pin(1'b0);
    end
    $display("test mode %h done", key);
  endtask
  task automatic test_amp();
    wait_pin(1'b0);
    apb(1'b1, CTRL2_OFF, ctrl2(3'h0, 1'b1, 3'h1, 2'h3, 6'h06));
    wait_pin(1'b1);
    wait_pin(1'b0);
    check({26'h0, amp_level}, 32'h2);
    cyc(200);
    check({26'h0, amp_level}, 32'h6);
    check({31'h0, amp_on}, 32'h1);
    check({30'h0, bias}, 32'h3);
    apb(1'b1, CTRL2_OFF, ctrl2(3'h0, 1'b0, 3'h1, 2'h3, 6'h06));
    cyc(40);
    check({31'h0, amp_on}, 32'h1);
    cyc(300);
    check({31'h0, amp_on}, 32'h0);
    check({26'h0, amp_level}, 32'h0);
    apb(1'b1, CTRL2_OFF, ctrl2(3'h0, 1'b1, 3'h1, 2'h3, 6'h06));
    cyc(300);
    // receive select cuts hard: no ramp down
    apb(1'b1, CTRL0_OFF, 32'h0800_0000);
    cyc(2);
    check({31'h0, amp_on}, 32'h0);
    check({26'h0, amp_level}, 32'h0);
    $display("test amp done");
  endtask
  // oversampled keying keeps the pin quiet; inverted clock keeps its period
  task automatic test_alt();
    time t;
    apb(1'b1, CTRL2_OFF, ctrl2(3'h4, 1'b0, 3'h0, 2'h1, 6'h0));
    cyc(40);
    check({31'h0, pin}, 32'h0);
    cyc(37);
    check({31'h0, pin}, 32'h0);
    apb(1'b0, STATUS_OFF, 32'h0);
    check(rd & 32'h0000_2000, 32'h0000_2000);
    apb(1'b1, CTRL2_OFF, ctrl2(3'h0, 1'b0, 3'h0, 2'h1, 6'h0) | (32'h1 << CLKINV_LSB));
    wait_pin(1'b1);
    t = $time;
    wait_pin(1'b0);
    wait_pin(1'b1);
    check(32'(($time - t) / 25), 32'h40);
    $display("test alt done");
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    cyc(12);
    presetn <= 1'b1;
    test_regs();
    test_clock();
    run_mode(3'h2, 1'b0, 10'b1011001001, 10, {3'h1, 3'h0, 3'h7, 3'h1, 3'h0, 3'h0, 3'h1,
             3'h0, 3'h0, 3'h7}, 1);
    run_mode(3'h3, 1'b0, 10'b0001111000, 10, {3'h5, 3'h7, 3'h1, 3'h3, 3'h5}, 2);
    run_mode(3'h0, 1'b1, 10'b1001, 4, {18'h0, 3'h1, 3'h7, 3'h7, 3'h1}, 1);
    test_amp();
    test_alt();
    finish_test();
  end
endmodule
`default_nettype wire
